// *** src/pvu_channel_update.sv ***
// one timer/PWM channel with buffered value update, Wishbone slave
`default_nettype none

module pvu_channel_update
    import pvu_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // timer environment
    input  wire logic        timer_tick_i,
    input  wire logic        debug_halt_mode_i,
    // pwm pin
    output logic             pwm_o
);
    logic [7:0]  timer_status_control;
    logic [15:0] timer_count;
    pvu_dir_e    count_dir;
    logic [15:0] counter_modulo_value;
    logic [15:0] channel_compare_value;
    logic        cv_pending;
    logic [7:0]  next_sc;
    logic [15:0] next_count;
    pvu_dir_e    next_dir;
    logic [15:0] next_mod;
    logic [15:0] next_cv;
    logic        next_pending;
    logic        next_pwm;
    logic [31:0] next_dat;
    logic        next_ack;
    logic        bus_req;
    logic        wr_fire;
    logic        lane0;
    logic        sc_write;
    logic        cnt_write;
    logic [15:0] mod_buf;
    logic        mod_done;
    logic [15:0] chan_buf;
    logic        chan_done;
    logic [1:0]  clks;
    logic        center_aligned_pwm;
    logic        count_en;
    logic [15:0] limit;
    logic        at_pre_limit;
    logic        xfer;

    // a write takes effect only at the edge that samples ack high
    assign bus_req   = cyc_i & stb_i;
    assign wr_fire   = bus_req & we_i & ack_o;
    assign lane0     = sel_i[0];
    assign sc_write  = wr_fire & lane0 & (adr_i == OFS_STATUS_CONTROL);
    assign cnt_write = wr_fire & (adr_i == OFS_COUNTER);

    // decoded control fields
    assign clks     = timer_status_control[SC_CLKS_LSB +: 2];
    assign center_aligned_pwm = timer_status_control[SC_CENTER_BIT];
    // counting freezes while halted for debug
    assign count_en = timer_tick_i & (clks != CLKS_NONE) & ~debug_halt_mode_i;

    // modulo of zero or all ones runs free
    assign limit = ((counter_modulo_value == FREE_MOD_ZERO) ||
                    (counter_modulo_value == FREE_LIMIT)) ? FREE_LIMIT
                                                          : counter_modulo_value;

    // step from limit-1 to limit, counting up in both modes
    assign at_pre_limit = count_en && (count_dir == PVU_UP) &&
                          (timer_count == limit - 16'h0001);

    // without a clock the value loads on completion, else at the step
    assign xfer = (clks == CLKS_NONE) ? chan_done
                                      : (cv_pending & at_pre_limit);

    // modulo halves; cleared only by a control write during debug halt
    pvu_byte_pair u_mod_pair (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .wr_hi_i (wr_fire & lane0 & (adr_i == OFS_MOD_HI)),
        .wr_lo_i (wr_fire & lane0 & (adr_i == OFS_MOD_LO)),
        .byte_i  (dat_i[7:0]),
        .clr_i   (sc_write & debug_halt_mode_i),
        .buf_o   (mod_buf),
        .done_o  (mod_done)
    );

    // channel halves; any control write with byte lane 0 restarts the pairing
    pvu_byte_pair u_chan_pair (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .wr_hi_i (wr_fire & lane0 & (adr_i == OFS_CHAN_HI)),
        .wr_lo_i (wr_fire & lane0 & (adr_i == OFS_CHAN_LO)),
        .byte_i  (dat_i[7:0]),
        .clr_i   (sc_write),
        .buf_o   (chan_buf),
        .done_o  (chan_done)
    );

    // bus answer: one wait state, unmapped reads give zero
    always_comb begin
        next_ack = bus_req & ~ack_o;
        next_dat = 32'h0000_0000;
        unique case (adr_i)
            OFS_STATUS_CONTROL: next_dat[7:0]  = timer_status_control;
            OFS_COUNTER:        next_dat[15:0] = timer_count;
            OFS_MOD_HI:         next_dat[7:0]  = counter_modulo_value[15:8];
            OFS_MOD_LO:         next_dat[7:0]  = counter_modulo_value[7:0];
            OFS_CHAN_HI:        next_dat[7:0]  = channel_compare_value[15:8];
            OFS_CHAN_LO:        next_dat[7:0]  = channel_compare_value[7:0];
            OFS_STATE: begin
                next_dat[15:0]           = channel_compare_value;
                next_dat[ST_PENDING_BIT] = cv_pending;
                next_dat[ST_DOWN_BIT]    = (count_dir == PVU_DOWN);
            end
            default:            next_dat = 32'h0000_0000;
        endcase
        if (!(bus_req && !ack_o)) begin
            next_dat = dat_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= next_ack;
            dat_o <= next_dat;
        end
    end

    // control register; unused bits stay zero
    always_comb begin
        next_sc = timer_status_control;
        if (sc_write) begin
            next_sc = dat_i[7:0] & SC_WR_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_status_control <= SC_RESET;
        end else begin
            timer_status_control <= next_sc;
        end
    end

    // counter: up-only in edge mode, up then down in center mode
    always_comb begin
        next_count = timer_count;
        next_dir   = count_dir;
        next_mod   = counter_modulo_value;
        if (mod_done) begin
            next_mod = mod_buf;
        end
        if (cnt_write) begin
            next_count = 16'h0000; // any write restarts, data ignored
            next_dir   = PVU_UP;
        end else if (count_en) begin
            if (!center_aligned_pwm) begin
                next_dir   = PVU_UP;
                next_count = (timer_count >= limit) ? 16'h0000 : timer_count + 16'h0001;
            end else begin
                unique case (count_dir)
                    PVU_UP: begin
                        if (timer_count >= limit) begin
                            next_dir   = PVU_DOWN;
                            next_count = timer_count - 16'h0001;
                        end else begin
                            next_count = timer_count + 16'h0001;
                        end
                    end
                    PVU_DOWN: begin
                        if (timer_count == 16'h0000) begin
                            next_dir   = PVU_UP;
                            next_count = 16'h0001;
                        end else begin
                            next_count = timer_count - 16'h0001;
                        end
                    end
                    default: begin
                        next_dir   = PVU_UP;
                        next_count = 16'h0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_count          <= 16'h0000;
            count_dir            <= PVU_UP;
            counter_modulo_value <= MOD_RESET;
        end else begin
            timer_count          <= next_count;
            count_dir            <= next_dir;
            counter_modulo_value <= next_mod;
        end
    end

    // with a clock the active value moves only at the period boundary, so a running period
    // always finishes with the duty it started with
    always_comb begin
        next_cv      = channel_compare_value;
        next_pending = chan_done | (cv_pending & ~xfer); // new completion wins
        if (xfer) begin
            next_cv = chan_buf;
        end
        if (clks == CLKS_NONE) begin
            next_pending = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_compare_value <= CHAN_RESET;
            cv_pending            <= 1'b0;
        end else begin
            channel_compare_value <= next_cv;
            cv_pending            <= next_pending;
        end
    end

    // output: active below the value; in center mode a value at or above the limit stays active,
    // which is the match-down set and match-up clear of the center mode
    always_comb begin
        next_pwm = (timer_count < channel_compare_value);
        if (center_aligned_pwm && (channel_compare_value >= limit)) begin
            next_pwm = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_o <= 1'b0;
        end else begin
            pwm_o <= next_pwm;
        end
    end

    // ack lasts one cycle
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    // clocked load happens only on the step into the limit
    load_point_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (clks != CLKS_NONE) && xfer && !cnt_write |=>
            (timer_count == $past(limit)) && (channel_compare_value == $past(chan_buf)))
        else $error("channel value loaded off the limit step");

    // active value is stable between loads
    value_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !xfer |=> $stable(channel_compare_value))
        else $error("channel value changed inside a period");

    // a free-running count loads a pending value on the step into all ones
    free_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cv_pending && !chan_done && count_en && !cnt_write && (count_dir == PVU_UP) &&
        (counter_modulo_value == FREE_MOD_ZERO) &&
        (timer_count == FREE_LIMIT - 16'h0001) |=>
            (channel_compare_value == $past(chan_buf)) && !cv_pending)
        else $error("free-running count missed the all-ones load");

    // center mode: full duty when the value reaches the limit
    full_duty_a: assert property (@(posedge clk_i) disable iff (rst_i)
        center_aligned_pwm && (channel_compare_value == limit) |=> pwm_o)
        else $error("center value equal to modulo not full duty");

    // modulo-1 keeps the output active below the turn
    near_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
        center_aligned_pwm && (channel_compare_value == limit - 16'h0001) &&
        (timer_count < channel_compare_value) |=> pwm_o)
        else $error("center value modulo-1 went inactive");

    // center count turns down at the limit
    turn_down_a: assert property (@(posedge clk_i) disable iff (rst_i)
        center_aligned_pwm && count_en && !cnt_write && count_dir == PVU_UP &&
        timer_count == limit |=> count_dir == PVU_DOWN)
        else $error("center counter did not turn at the limit");

    // without a clock the completed value lands the next cycle
    direct_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (clks == CLKS_NONE) && chan_done |=> channel_compare_value == $past(chan_buf))
        else $error("unclocked channel value not loaded at once");

    // a clocked zero change waits for the boundary
    zero_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (clks != CLKS_NONE) && cv_pending && !at_pre_limit |=>
            channel_compare_value == $past(channel_compare_value))
        else $error("pending value applied mid period");
endmodule : pvu_channel_update

`default_nettype wire

// *** src/pvu_pkg.sv ***
// constants shared by the channel value update block
//
// Overview of operation
// - edge PWM loads channel at modulo-1 to modulo
// - free-running counter loads at FFFE to FFFF
// - center PWM loads channel at modulo-1 to modulo
// - center PWM, value equal modulo gives 100%
// - center PWM, modulo-1 gives near 100% duty
// - zero to non-zero waits for next period
// - non-zero to zero finishes current period first
// - control write in debug halt clears modulo halves
// - center counts up then down, match sets/clears
// - modulo zero or FFFF means free running
// - control write clears channel byte coherency
`default_nettype none

package pvu_pkg;
    // register byte offsets on the bus
    localparam logic [7:0]  OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0]  OFS_COUNTER        = 8'h04;
    localparam logic [7:0]  OFS_MOD_HI         = 8'h08;
    localparam logic [7:0]  OFS_MOD_LO         = 8'h0C;
    localparam logic [7:0]  OFS_CHAN_HI        = 8'h10;
    localparam logic [7:0]  OFS_CHAN_LO        = 8'h14;
    localparam logic [7:0]  OFS_STATE          = 8'h18;
    // status/control field layout and reset
    localparam int          SC_CLKS_LSB        = 3;
    localparam int          SC_CENTER_BIT      = 5;
    localparam logic [7:0]  SC_RESET           = 8'h00;
    localparam logic [7:0]  SC_WR_MASK         = 8'h38;
    // state register field positions
    localparam int          ST_PENDING_BIT     = 16;
    localparam int          ST_DOWN_BIT        = 17;
    // value resets and limits
    localparam logic [15:0] MOD_RESET          = 16'h0000;
    localparam logic [15:0] CHAN_RESET         = 16'h0000;
    localparam logic [15:0] FREE_LIMIT         = 16'hFFFF;
    localparam logic [15:0] FREE_MOD_ZERO      = 16'h0000;
    localparam logic [1:0]  CLKS_NONE          = 2'h0;

    // counter direction, one-hot
    typedef enum logic [1:0] {
        PVU_UP   = 2'b01,
        PVU_DOWN = 2'b10
    } pvu_dir_e;
endpackage : pvu_pkg

`default_nettype wire

// *** src/pvu_byte_pair.sv ***
// two-byte write coherency for a 16-bit register
`default_nettype none

module pvu_byte_pair
    import pvu_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // byte writes
    input  wire logic        wr_hi_i,
    input  wire logic        wr_lo_i,
    input  wire logic [7:0]  byte_i,
    input  wire logic        clr_i,
    // assembled value
    output logic      [15:0] buf_o,
    output logic             done_o
);
    logic        hi_seen;
    logic        lo_seen;
    logic        next_hi_seen;
    logic        next_lo_seen;
    logic [15:0] next_buf;
    logic        next_done;

    // halves may come in either order; a clear drops a half-written value
    always_comb begin
        next_buf     = buf_o;
        next_hi_seen = hi_seen | wr_hi_i;
        next_lo_seen = lo_seen | wr_lo_i;
        next_done    = 1'b0;
        if (wr_hi_i) begin
            next_buf[15:8] = byte_i;
        end
        if (wr_lo_i) begin
            next_buf[7:0] = byte_i;
        end
        if (clr_i) begin
            next_hi_seen = 1'b0;
            next_lo_seen = 1'b0;
        end else if (next_hi_seen && next_lo_seen) begin
            next_done    = 1'b1;
            next_hi_seen = 1'b0;
            next_lo_seen = 1'b0;
        end
    end

    // registers only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_o   <= 16'h0000;
            hi_seen <= 1'b0;
            lo_seen <= 1'b0;
            done_o  <= 1'b0;
        end else begin
            buf_o   <= next_buf;
            hi_seen <= next_hi_seen;
            lo_seen <= next_lo_seen;
            done_o  <= next_done;
        end
    end

    // a clear leaves no half behind
    clear_halves_a: assert property (@(posedge clk_i) disable iff (rst_i)
        clr_i |=> (!hi_seen && !lo_seen && !done_o))
        else $error("byte pair clear left a half pending");
endmodule : pvu_byte_pair

`default_nettype wire

// *** verification/pvu_pin_monitor.sv ***
// pwm pin watcher: counts active cycles of the pin over a window
`default_nettype none

module pvu_pin_monitor (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // window control and pin
    input  wire logic        clr_i,
    input  wire logic        tick_i,
    input  wire logic        pwm_i,
    // result
    output logic      [15:0] high_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] tick_q;

    // two stages: counter lags the tick and the pin lags the counter
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            tick_q     <= 2'h0;
            high_cnt_o <= 16'h0000;
        end else begin
            tick_q <= {tick_q[0], tick_i};
            if (tick_q[1] && pwm_i) begin
                high_cnt_o <= high_cnt_o + 16'h0001;
            end
        end
    end
endmodule : pvu_pin_monitor

`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the channel value update block
`default_nettype none

module tb_top
    import pvu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i, rst_i, cyc, stb, we, tick, halt, mon_clr, ack, pwm;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [15:0] high_cnt;
    int          bad_count, compares;

    pvu_channel_update dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .timer_tick_i(tick), .debug_halt_mode_i(halt), .pwm_o(pwm));
    pvu_pin_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .clr_i(mon_clr), .tick_i(tick),
        .pwm_i(pwm), .high_cnt_o(high_cnt));

    // 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic wrap_up();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one classic cycle; ack and read data are taken at the same edge
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk("ack wait", 32'h1, 32'h0);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (w) repeat (2) @(posedge clk_i); // paired value loads one edge after the write edge
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(a, 1'b1, d);
    endtask : wr

    // high byte first, low byte sits four bytes above it
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, {24'h0, v[15:8]});
        wr(a + 8'h04, {24'h0, v[7:0]});
    endtask : wr16

    task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
        wb(a, 1'b0, 32'h0);
        chk(nm, e, q);
    endtask : rd

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_i);
            tick <= 1'b1;
        end
        @(posedge clk_i);
        tick <= 1'b0;
    endtask : ticks

    // active cycles of the pin over n counts
    task automatic measure(input int n);
        @(posedge clk_i);
        mon_clr <= 1'b1;
        @(posedge clk_i);
        mon_clr <= 1'b0;
        ticks(n);
        repeat (3) @(posedge clk_i);
    endtask : measure

    // watchdog: the run needs about 70k cycles
    initial begin
        #900us;
        chk("watchdog", 32'h1, 32'h0);
        wrap_up();
    end

    // main sequence
    initial begin
        {rst_i, cyc, stb, we, tick, halt, mon_clr} = 7'b1000000;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0;
        bad_count = 0;
        compares = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_STATE, "state", 32'h0);
        rd(OFS_STATUS_CONTROL, "status", 32'h0);
        wr(8'h1C, 32'hFF);
        rd(8'h1C, "unmapped", 32'h0);
        wr16(OFS_CHAN_HI, 16'h1234);
        rd(OFS_STATE, "state", 32'h0000_1234);
        wr(OFS_STATUS_CONTROL, 32'h08);
        wr16(OFS_MOD_HI, 16'h0010);
        wr(OFS_COUNTER, 32'h0);
        wr16(OFS_CHAN_HI, 16'h0005);
        ticks(15);
        rd(OFS_STATE, "state", 32'h0001_1234);
        ticks(1);
        rd(OFS_COUNTER, "counter", 32'h0000_0010);
        rd(OFS_STATE, "state", 32'h0000_0005);
        // edge mode: counts 0..16 with value 5 give five active counts
        measure(17);
        chk("edge duty", 32'h5, {16'h0, high_cnt});
        // free running: modulo zero, load at the top step
        wr16(OFS_MOD_HI, 16'h0000);
        wr(OFS_COUNTER, 32'h0);
        wr16(OFS_CHAN_HI, 16'h0042);
        ticks(16'hFFFE);
        rd(OFS_STATE, "state", 32'h0001_0005);
        ticks(1);
        rd(OFS_STATE, "state", 32'h0000_0042);
        // half-written modulo dropped by a control write while halted
        halt <= 1'b1;
        wr(OFS_MOD_HI, 32'h00);
        wr(OFS_STATUS_CONTROL, 32'h08);
        wr(OFS_MOD_LO, 32'h08);
        halt <= 1'b0;
        wr(OFS_COUNTER, 32'h0);
        ticks(9);
        rd(OFS_COUNTER, "counter", 32'h0000_0009);
        wr(OFS_CHAN_HI, 32'h00);
        wr(OFS_STATUS_CONTROL, 32'h08);
        wr(OFS_CHAN_LO, 32'h03);
        rd(OFS_STATE, "state", 32'h0000_0042);
        // center aligned, control first so both pairings restart
        halt <= 1'b1;
        wr(OFS_STATUS_CONTROL, 32'h28);
        halt <= 1'b0;
        wr16(OFS_MOD_HI, 16'h0008);
        wr(OFS_COUNTER, 32'h0);
        wr16(OFS_CHAN_HI, 16'h0008);
        ticks(9);
        rd(OFS_COUNTER, "counter", 32'h0000_0007);
        rd(OFS_STATE, "state", 32'h0002_0008);
        measure(16);
        chk("high count", 32'd16, {16'h0, high_cnt});
        wr16(OFS_CHAN_HI, 16'h0007);
        ticks(16);
        measure(16);
        chk("near full", 32'h1, {31'h0, high_cnt > 16'd8 && high_cnt < 16'd16});
        wr16(OFS_CHAN_HI, 16'h0000);
        rd(OFS_STATE, "state", 32'h0003_0007);
        // running period still uses value 7 until the step into the top
        measure(16);
        chk("old duty", 32'hD, {16'h0, high_cnt});
        measure(16);
        chk("high count", 32'd0, {16'h0, high_cnt});
        wr16(OFS_CHAN_HI, 16'h0005);
        rd(OFS_STATE, "state", 32'h0003_0000);
        // the zero period runs out unchanged, the new duty follows after it
        measure(16);
        chk("zero hold", 32'h0, {16'h0, high_cnt});
        rd(OFS_STATE, "state", 32'h0002_0005);
        measure(16);
        chk("new duty", 32'h9, {16'h0, high_cnt});
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
